// ### logic/fcu_pkg.sv
// package: opcodes, field positions and flag layout of the compare unit
`default_nettype none
package fcu_pkg;
    localparam logic [5:0] OP_SGT     = 6'h39;
    localparam logic [5:0] OP_DLT     = 6'h2A;
    localparam logic [5:0] OP_SLT     = 6'h3A;
    localparam logic [3:0] LOW_FIXED  = 4'h8;
    localparam int         OP_LSB     = 6;
    localparam int         DST_LSB    = 23;
    localparam int         SECOND_SOURCE_LSB   = 18;
    localparam int         FIRST_SOURCE_LSB   = 13;
    localparam int         XPATH_BIT  = 12;
    localparam int         FIX_LSB    = 2;
    localparam int         SP_EXP_W   = 8;
    localparam int         SP_MAN_W   = 23;
    localparam int         DP_EXP_W   = 11;
    localparam int         DP_MAN_W   = 52;
    localparam logic [4:0] REG_RST    = 5'h00;
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;
    // flag vector layout
    localparam int FL_UNORDERED_FLAG = 0;
    localparam int FL_INVALID_OP_FLAG = 1;
    localparam int FL_NAN1  = 2;
    localparam int FL_NAN2  = 3;
    localparam int FL_DEN1  = 4;
    localparam int FL_DEN2  = 5;
    localparam int FL_W     = 6;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    typedef enum logic [1:0] {
        FCU_IDLE = 2'b01,
        FCU_HIGH = 2'b10
    } fcu_state_t;
endpackage
`default_nettype wire

// ### logic/fcu_cmp_core.sv
// leaf: classifies two floats and orders them
`timescale 1ns/1ps
`default_nettype none
module fcu_cmp_core #(
    parameter int EXP_W = 8,
    parameter int MAN_W = 23
) (
    input  wire logic [EXP_W+MAN_W:0] a_i,
    input  wire logic [EXP_W+MAN_W:0] b_i,
    output logic                      a_nan_o,
    output logic                      b_nan_o,
    output logic                      a_den_o,
    output logic                      b_den_o,
    output logic                      a_lt_b_o,
    output logic                      a_gt_b_o
);
    localparam int W = EXP_W + MAN_W + 1;
    wire logic [EXP_W-1:0] a_exp = a_i[W-2:MAN_W];
    wire logic [EXP_W-1:0] b_exp = b_i[W-2:MAN_W];
    wire logic [MAN_W-1:0] a_man = a_i[MAN_W-1:0];
    wire logic [MAN_W-1:0] b_man = b_i[MAN_W-1:0];
    wire logic a_zero = (a_exp == '0);
    wire logic b_zero = (b_exp == '0);
    assign a_nan_o = (&a_exp) && (a_man != '0);
    assign b_nan_o = (&b_exp) && (b_man != '0);
    assign a_den_o = a_zero && (a_man != '0);
    assign b_den_o = b_zero && (b_man != '0);
    // denormals flush to zero of either sign; magnitude compare then sign
    wire logic [W-2:0] a_mag = a_zero ? '0 : a_i[W-2:0];
    wire logic [W-2:0] b_mag = b_zero ? '0 : b_i[W-2:0];
    wire logic a_neg = a_i[W-1] && !a_zero;
    wire logic b_neg = b_i[W-1] && !b_zero;
    wire logic mag_lt = a_mag < b_mag;
    wire logic mag_gt = a_mag > b_mag;
    wire logic unordered_flag = a_nan_o || b_nan_o;
    wire logic lt_raw = (a_neg && !b_neg) ||
                        (!a_neg && !b_neg && mag_lt) ||
                        (a_neg && b_neg && mag_gt);
    wire logic gt_raw = (!a_neg && b_neg) ||
                        (!a_neg && !b_neg && mag_gt) ||
                        (a_neg && b_neg && mag_lt);
    assign a_lt_b_o = lt_raw && !unordered_flag; // RULE13
    assign a_gt_b_o = gt_raw && !unordered_flag; // RULE13
endmodule
`default_nettype wire

// ### logic/fcu_top.sv
// float compare unit: single greater-than and less-than, double less-than
//
// Contract
// RULE1: opcode 111001 writes 1 when first source exceeds second, else 0.
// RULE2: opcode 101010 with low fixed bits 1000 is double less-than.
// RULE3: opcode 111010 with the same fixed bits is single less-than.
// RULE4: dst is bits 27-23, second source 22-18, first 17-13, cross 12.
// RULE5: less-than writes 1 when first is strictly below second, else 0.
// RULE6: a NaN source forces 0 and sets unordered and invalid flags.
// RULE7: only unordered, invalid and per-source NaN/denormal flags change.
// RULE8: single compares take single sources, second maybe cross path.
// RULE9: double compare takes register pairs, second maybe cross path.
// RULE10: a false predicate writes nothing and sets no flag.
// RULE11: single compares read and write in one stage, zero delay slots.
// RULE12: double reads low words first stage, high words and writes second.
// RULE13: zero and denormal compare equal; infinities bound everything.
`timescale 1ns/1ps
`default_nettype none
module fcu_top (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        issue_i,
    input  wire logic        pred_true_i,
    input  wire logic [31:0] instr_i,
    input  wire logic        unit_side_b_i,
    input  wire logic [31:0] first_source_i,
    input  wire logic [31:0] second_source_i,
    input  wire logic [31:0] cross_source_i,
    output logic             busy_o,
    output logic [4:0]       first_addr_o,
    output logic [4:0]       second_addr_o,
    output logic             cross_sel_o,
    output logic             high_word_o,
    output logic             wr_en_o,
    output logic [4:0]       wr_addr_o,
    output logic [31:0]      wr_data_o,
    output logic             s_unit_side_a_o,
    output logic             s_unit_side_b_o,
    output logic             flags_set_o,
    output logic [5:0]       flags_o
);
    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire logic [5:0] op  = instr_i[fcu_pkg::OP_LSB +: 6];
    wire logic [3:0] fix = instr_i[fcu_pkg::FIX_LSB +: 4];
    wire logic fix_ok = (fix == fcu_pkg::LOW_FIXED);
    wire logic dec_sgt = fix_ok && (op == fcu_pkg::OP_SGT); // RULE1
    wire logic dec_dlt = fix_ok && (op == fcu_pkg::OP_DLT); // RULE2
    wire logic dec_slt = fix_ok && (op == fcu_pkg::OP_SLT); // RULE3
    wire logic [4:0] dst_f  = instr_i[fcu_pkg::DST_LSB +: 5];  // RULE4
    wire logic [4:0] second_source_f = instr_i[fcu_pkg::SECOND_SOURCE_LSB +: 5]; // RULE4
    wire logic [4:0] first_source_f = instr_i[fcu_pkg::FIRST_SOURCE_LSB +: 5]; // RULE4
    wire logic xsel_f = instr_i[fcu_pkg::XPATH_BIT];           // RULE4

    fcu_pkg::fcu_state_t state_reg;
    fcu_pkg::fcu_state_t state_next;
    logic [31:0] lo1_reg;
    logic [31:0] lo2_reg;
    logic [4:0]  dst_reg;
    logic        xsel_reg;
    logic [4:0]  s1_reg;
    logic [4:0]  s2_reg;
    logic        side_reg;

    wire logic idle = (state_reg == fcu_pkg::FCU_IDLE);
    // a predicated-off op behaves as a no-operation
    wire logic go = idle && issue_i && pred_true_i; // RULE10
    wire logic go_sp = go && (dec_sgt || dec_slt);
    wire logic go_dp = go && dec_dlt;

    // source address and cross-path steering seen by the register file
    assign busy_o        = !idle;
    assign high_word_o   = !idle;
    assign first_addr_o  = idle ? first_source_f : s1_reg;
    assign second_addr_o = idle ? second_source_f : s2_reg;
    assign cross_sel_o   = idle ? xsel_f : xsel_reg;
    // second source may come over the cross path
    wire logic [31:0] b_word = cross_sel_o ? cross_source_i
                                           : second_source_i; // RULE8 RULE9

    // ---------------------------------------------------------------
    // comparators
    // ---------------------------------------------------------------
    logic sp_an, sp_bn, sp_ad, sp_bd, sp_lt, sp_gt;
    fcu_cmp_core #(.EXP_W(fcu_pkg::SP_EXP_W), .MAN_W(fcu_pkg::SP_MAN_W))
    u_sp (
        .a_i      (first_source_i),
        .b_i      (b_word),
        .a_nan_o  (sp_an),
        .b_nan_o  (sp_bn),
        .a_den_o  (sp_ad),
        .b_den_o  (sp_bd),
        .a_lt_b_o (sp_lt),
        .a_gt_b_o (sp_gt)
    ); // RULE8

    logic dp_an, dp_bn, dp_ad, dp_bd, dp_lt;
    // high words arrive in the second stage, low words were latched
    fcu_cmp_core #(.EXP_W(fcu_pkg::DP_EXP_W), .MAN_W(fcu_pkg::DP_MAN_W))
    u_dp (
        .a_i      ({first_source_i, lo1_reg}),
        .b_i      ({b_word, lo2_reg}),
        .a_nan_o  (dp_an),
        .b_nan_o  (dp_bn),
        .a_den_o  (dp_ad),
        .b_den_o  (dp_bd),
        .a_lt_b_o (dp_lt),
        .a_gt_b_o ()
    ); // RULE9 RULE12

    // ---------------------------------------------------------------
    // result selection
    // ---------------------------------------------------------------
    wire logic sp_bit = dec_sgt ? sp_gt : sp_lt;    // RULE1 RULE5
    wire logic res_bit = idle ? sp_bit : dp_lt;     // RULE5
    wire logic an = idle ? sp_an : dp_an;
    wire logic bn = idle ? sp_bn : dp_bn;
    wire logic ad = idle ? sp_ad : dp_ad;
    wire logic bd = idle ? sp_bd : dp_bd;
    wire logic wr_now = go_sp || !idle;             // RULE11 RULE12
    wire logic unordered_flag = an || bn;
    // only these six flags are ever driven
    wire logic [5:0] flag_vec = {bd, ad, bn, an, unordered_flag, unordered_flag}; // RULE6 RULE7

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            fcu_pkg::FCU_IDLE: begin
                if (go_dp) begin
                    state_next = fcu_pkg::FCU_HIGH;
                end
            end
            fcu_pkg::FCU_HIGH: begin
                state_next = fcu_pkg::FCU_IDLE;
            end
            default: begin
                state_next = fcu_pkg::FCU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= fcu_pkg::FCU_IDLE;
            lo1_reg   <= fcu_pkg::WORD_RST;
            lo2_reg   <= fcu_pkg::WORD_RST;
            dst_reg   <= fcu_pkg::REG_RST;
            s1_reg    <= fcu_pkg::REG_RST;
            s2_reg    <= fcu_pkg::REG_RST;
            xsel_reg  <= 1'b0;
            side_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (go_dp) begin
                lo1_reg  <= first_source_i; // RULE12
                lo2_reg  <= b_word;         // RULE12
                dst_reg  <= dst_f;
                s1_reg   <= first_source_f;
                s2_reg   <= second_source_f;
                xsel_reg <= xsel_f;
                side_reg <= unit_side_b_i;
            end
        end
    end

    // registered write-back: result visible the cycle after the write edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_en_o         <= 1'b0;
            wr_addr_o       <= fcu_pkg::REG_RST;
            wr_data_o       <= fcu_pkg::WORD_RST;
            flags_set_o     <= 1'b0;
            flags_o         <= fcu_pkg::FLAGS_RST;
            s_unit_side_a_o <= 1'b0;
            s_unit_side_b_o <= 1'b0;
        end else begin
            wr_en_o         <= wr_now;                     // RULE10
            flags_set_o     <= wr_now;                     // RULE10
            wr_addr_o       <= idle ? dst_f : dst_reg;
            // a NaN forces 0 via the comparator gating
            wr_data_o       <= {31'h0000_0000, res_bit && wr_now}; // RULE6
            flags_o         <= wr_now ? flag_vec : fcu_pkg::FLAGS_RST; // RULE7
            s_unit_side_a_o <= wr_now && !(idle ? unit_side_b_i : side_reg);
            s_unit_side_b_o <= wr_now && (idle ? unit_side_b_i : side_reg);
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_dp_issue;
        go_dp;
    endsequence
    sequence s_dp_write;
        !idle ##1 wr_en_o;
    endsequence

    a_sp_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        go_sp |=> wr_en_o && wr_addr_o == $past(dst_f)) // RULE11
        else $error("single compare did not write next cycle");
    a_dp_two_stage: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_dp_issue |=> s_dp_write) // RULE12
        else $error("double compare did not write in second stage");
    a_dp_no_early: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        go_dp && !go_sp |=> !wr_en_o) // RULE12
        else $error("double compare wrote early");
    a_pred_false_nop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        idle && !(issue_i && pred_true_i) |=> !wr_en_o && flags_o == 6'h00) // RULE10
        else $error("no-operation changed state");
    a_nan_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_en_o && flags_o[fcu_pkg::FL_UNORDERED_FLAG] |-> wr_data_o == 32'h0000_0000) // RULE6
        else $error("nan compare wrote nonzero");
    a_nan_flags: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_en_o && (flags_o[fcu_pkg::FL_NAN1] || flags_o[fcu_pkg::FL_NAN2])
        |-> flags_o[fcu_pkg::FL_UNORDERED_FLAG] && flags_o[fcu_pkg::FL_INVALID_OP_FLAG]) // RULE6
        else $error("nan seen without unordered and invalid");
    a_flags_only_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !wr_en_o |-> flags_o == 6'h00) // RULE7
        else $error("flags moved with no write");
    a_result_one_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_data_o[31:1] == 31'h0000_0000) // RULE5
        else $error("result not 0 or 1");
    a_gt_result: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        go_sp && dec_sgt |=> wr_data_o[0] == $past(sp_gt)) // RULE1
        else $error("greater-than result wrong");
    a_side_onehot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_en_o |-> s_unit_side_a_o != s_unit_side_b_o) // RULE8
        else $error("result unit side not unique");
endmodule
`default_nettype wire

// ### tb/fcu_regfile_model.sv
// register file model behind the compare unit's read ports
`timescale 1ns/1ps
`default_nettype none
module fcu_regfile_model (
    input  wire logic [4:0]  first_addr_i,
    input  wire logic [4:0]  second_addr_i,
    input  wire logic        cross_sel_i,
    input  wire logic        high_word_i,
    output logic      [31:0] first_source_o,
    output logic      [31:0] second_source_o,
    output logic      [31:0] cross_source_o
);
    // ----------------------------------------
    // storage, loaded by the bench
    // ----------------------------------------
    logic [31:0] lo_m  [32];
    logic [31:0] hi_m  [32];
    logic [31:0] xlo_m [32];
    logic [31:0] xhi_m [32];
    // odd word of the pair served while high words are asked for
    assign first_source_o  = high_word_i ? hi_m[first_addr_i]
                                         : lo_m[first_addr_i];
    assign second_source_o = high_word_i ? hi_m[second_addr_i]
                                         : lo_m[second_addr_i];
    // unselected cross path shows inverted data, never a stale match
    assign cross_source_o  = (high_word_i ? xhi_m[second_addr_i]
                                          : xlo_m[second_addr_i])
                             ^ {32{!cross_sel_i}};
endmodule
`default_nettype wire

// ### tb/fcu_top_test.sv
// self-checking bench for the float compare unit
`timescale 1ns/1ps
`default_nettype none
module fcu_top_test;
    logic clk_sys_i, rst_n_i, issue_i, pred_true_i, unit_side_b_i;
    logic [31:0] instr_i, first_source_i, second_source_i, cross_source_i;
    logic busy_o, cross_sel_o, high_word_o, wr_en_o, flags_set_o;
    logic s_unit_side_a_o, s_unit_side_b_o;
    logic [4:0]  first_addr_o, second_addr_o, wr_addr_o;
    logic [31:0] wr_data_o;
    logic [5:0]  flags_o;
    int          err_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    fcu_top dut_u (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .issue_i(issue_i),
        .pred_true_i(pred_true_i), .instr_i(instr_i),
        .unit_side_b_i(unit_side_b_i), .first_source_i(first_source_i),
        .second_source_i(second_source_i), .cross_source_i(cross_source_i),
        .busy_o(busy_o), .first_addr_o(first_addr_o),
        .second_addr_o(second_addr_o), .cross_sel_o(cross_sel_o),
        .high_word_o(high_word_o), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o),
        .wr_data_o(wr_data_o), .s_unit_side_a_o(s_unit_side_a_o),
        .s_unit_side_b_o(s_unit_side_b_o), .flags_set_o(flags_set_o),
        .flags_o(flags_o));
    fcu_regfile_model rf_u (
        .first_addr_i(first_addr_o), .second_addr_i(second_addr_o),
        .cross_sel_i(cross_sel_o), .high_word_i(high_word_o),
        .first_source_o(first_source_i), .second_source_o(second_source_i),
        .cross_source_o(cross_source_i));
    // ----------------------------------------
    // helpers and reference
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors=%0d checks=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] mk(input logic [5:0] op, input logic x,
                                       input logic [3:0] fx);
        mk = {4'h0, 5'h05, 5'h07, 5'h03, x, op, fx, 2'b00};
    endfunction
    function automatic bit is_nan(input logic [63:0] v, input bit dp);
        is_nan = dp ? (&v[62:52] && |v[51:0]) : (&v[30:23] && |v[22:0]);
    endfunction
    function automatic bit is_den(input logic [63:0] v, input bit dp);
        is_den = dp ? (v[62:52] == 11'h0 && |v[51:0])
                    : (v[30:23] == 8'h0 && |v[22:0]);
    endfunction
    // zeros and denormals of either sign collapse to one key
    function automatic logic signed [64:0] key(input logic [63:0] v,
                                               input bit dp);
        logic [62:0] mag;
        mag = dp ? v[62:0] : {32'h0, v[30:0]};
        if (dp ? v[62:52] == 11'h0 : v[30:23] == 8'h0) mag = '0;
        key = (dp ? v[63] : v[31]) ? -$signed({2'b00, mag})
                                   : $signed({2'b00, mag});
    endfunction
    task automatic do_op(input logic [5:0] op, input logic [63:0] a, b,
                         input bit pred, xs, side);
        bit dp, n1, n2;
        logic [31:0] r;
        logic [5:0] f;
        dp = (op == fcu_pkg::OP_DLT);
        n1 = is_nan(a, dp);
        n2 = is_nan(b, dp);
        r = 32'h0;
        if (!n1 && !n2) r[0] = (op == fcu_pkg::OP_SGT) ? key(a, dp) > key(b, dp)
                                                     : key(a, dp) < key(b, dp);
        f = {is_den(b, dp), is_den(a, dp), n2, n1, n1 | n2, n1 | n2};
        {rf_u.hi_m[3], rf_u.lo_m[3]} = a;
        {rf_u.hi_m[7], rf_u.lo_m[7]} = xs ? ~b : b;
        {rf_u.xhi_m[7], rf_u.xlo_m[7]} = xs ? b : ~b;
        @(negedge clk_sys_i);
        instr_i = mk(op, xs, fcu_pkg::LOW_FIXED);
        pred_true_i = pred;
        unit_side_b_i = side;
        issue_i = 1'b1;
        #1;
        chk(first_addr_o, 5'h03);
        chk(second_addr_o, 5'h07);
        chk(cross_sel_o, xs);
        @(negedge clk_sys_i);
        if (dp && pred) begin
            chk(busy_o, 1'b1);
            chk(high_word_o, 1'b1);
            chk(wr_en_o, 1'b0);
            @(negedge clk_sys_i);
        end
        issue_i = 1'b0;
        chk(busy_o, 1'b0);
        chk(wr_en_o, pred);
        chk(flags_set_o, pred);
        chk(flags_o, pred ? f : 6'h00);
        if (pred) begin
            chk(wr_data_o, r);
            chk(wr_addr_o, 5'h05);
            chk(s_unit_side_b_o, side);
            chk(s_unit_side_a_o, !side);
        end
        @(negedge clk_sys_i);
        chk(wr_en_o, 1'b0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_single;
        logic [31:0] av [8] = '{32'hC0200000, 32'h00000000, 32'h80000000,
            32'h7F800000, 32'hFF800000, 32'h7FC00000, 32'h3F800000,
            32'hBF800000};
        logic [31:0] bv [8] = '{32'h4109999A, 32'h00000001, 32'h00000000,
            32'h7F7FFFFF, 32'hFF7FFFFF, 32'h3F800000, 32'h7F800001,
            32'hC0000000};
        for (int i = 0; i < 16; i++) begin
            do_op(i < 8 ? fcu_pkg::OP_SGT : fcu_pkg::OP_SLT, {32'h0, av[i % 8]},
                  {32'h0, bv[i % 8]}, 1'b1, i[0], i[1]);
        end
    endtask
    task automatic t_double;
        logic [63:0] av [6] = '{64'hC004000000000000, 64'h3FF0000000000000,
            64'h4000000000000000, 64'h7FF8000000000000,
            64'h0000000000000001, 64'hFFF0000000000000};
        logic [63:0] bv [6] = '{64'h4021333333333333, 64'h3FF0000000000001,
            64'h3FF0000000000000, 64'h3FF0000000000000,
            64'h8000000000000000, 64'hFFEFFFFFFFFFFFFF};
        for (int i = 0; i < 6; i++) begin
            do_op(fcu_pkg::OP_DLT, av[i], bv[i], 1'b1, i[0], i[1]);
        end
    endtask
    task automatic t_pred_false;
        do_op(fcu_pkg::OP_SGT, 64'h3F800000, 64'h0, 1'b0, 1'b0, 1'b0);
        do_op(fcu_pkg::OP_DLT, 64'h7FF8000000000000, 64'h0, 1'b0, 1'b1,
              1'b1);
    endtask
    // wrong fixed bits or a foreign opcode must leave the unit silent
    task automatic t_ignored;
        logic [31:0] bad [3] = '{mk(fcu_pkg::OP_SGT, 1'b0, 4'h0),
            mk(fcu_pkg::OP_SLT, 1'b0, 4'h9), mk(6'h38, 1'b0, 4'h8)};
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys_i);
            instr_i = bad[i];
            pred_true_i = 1'b1;
            issue_i = 1'b1;
            @(negedge clk_sys_i);
            issue_i = 1'b0;
            chk(wr_en_o, 1'b0);
            chk(busy_o, 1'b0);
        end
    endtask
    // reset in the second stage abandons the double compare
    task automatic t_reset;
        @(negedge clk_sys_i);
        instr_i = mk(fcu_pkg::OP_DLT, 1'b0, fcu_pkg::LOW_FIXED);
        pred_true_i = 1'b1;
        issue_i = 1'b1;
        @(negedge clk_sys_i);
        issue_i = 1'b0;
        chk(busy_o, 1'b1);
        rst_n_i = 1'b0;
        @(negedge clk_sys_i);
        chk(busy_o, 1'b0);
        chk(wr_en_o, 1'b0);
        rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        chk(wr_en_o, 1'b0);
        chk(busy_o, 1'b0);
    endtask
    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        issue_i = 1'b0;
        pred_true_i = 1'b0;
        unit_side_b_i = 1'b0;
        instr_i = 32'h0;
        repeat (10) @(negedge clk_sys_i);
        chk(wr_en_o, 1'b0);
        chk(flags_o, 6'h00);
        rst_n_i = 1'b1;
        t_single();
        t_double();
        t_pred_false();
        t_ignored();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
